// >>> logic/fcs_host.sv
// Host-side controller that turns user requests into flash bus cycles.
// Assumes the flash pins connect directly; data pins are three signals.
`timescale 1ns/10ps
`default_nettype none
module fcs_host
    import fcs_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire fcs_req_t i_req,
    output logic o_req_ready,
    output logic o_rd_valid,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_gap_expired,
    output logic o_timeout_fail,
    output logic o_erase_window,
    output fcs_ctl_t o_ctl,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [DATA_W-1:0] i_dq_in
);
    // ******************************************************************
    // Sequence table
    // ******************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_PULSE,
        ST_HOLD,
        ST_RD_GATE,
        ST_RD_DONE
    } fcs_state_t;

    fcs_state_t state, next_state;
    logic [2:0] cyc, next_cyc;
    logic [2:0] last_cyc, next_last_cyc;
    logic [3:0] tmr, next_tmr;
    logic [12:0] gap, next_gap;
    fcs_req_t req, next_req;
    fcs_ctl_t ctl, next_ctl;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [DATA_W-1:0] dq_out, next_dq_out;
    logic dq_oe, next_dq_oe;
    logic ready, next_ready;
    logic rd_valid, next_rd_valid;
    logic [DATA_W-1:0] rd_data, next_rd_data;
    logic gap_exp, next_gap_exp;
    logic tfail, next_tfail;
    logic ewin, next_ewin;
    logic [DATA_W-1:0] dq_s1, dq_s2;
    logic [ADDR_W-1:0] cyc_addr;
    logic [DATA_W-1:0] cyc_data;

    // Address and data of write cycle number cyc for the held request.
    always_comb begin
        cyc_addr = ADDR_UNLOCK1;
        cyc_data = DATA_UNLOCK1;
        unique case (cyc)
            3'h0: begin
                cyc_addr = ADDR_UNLOCK1;
                cyc_data = DATA_UNLOCK1;
            end
            3'h1, 3'h4: begin
                cyc_addr = ADDR_UNLOCK2;
                cyc_data = DATA_UNLOCK2;
            end
            3'h2: begin
                cyc_addr = ADDR_UNLOCK1;
                unique case (req.op)
                    FCS_OP_AUTOSEL: cyc_data = CMD_AUTOSEL;
                    FCS_OP_PROGRAM: cyc_data = CMD_PROGRAM;
                    default: cyc_data = CMD_ERASE;
                endcase
            end
            3'h3: begin
                if (req.op == FCS_OP_PROGRAM) begin
                    cyc_addr = req.addr;
                    cyc_data = req.data;
                end else begin
                    cyc_addr = ADDR_UNLOCK1;
                    cyc_data = DATA_UNLOCK1;
                end
            end
            default: begin
                if (req.op == FCS_OP_CHIP_ERASE) begin
                    cyc_addr = ADDR_UNLOCK1;
                    cyc_data = CMD_CHIP;
                end else begin
                    // Only the sector bits matter here.
                    cyc_addr = {req.addr[ADDR_W-1:SECT_LSB],
                        16'h0000};
                    cyc_data = CMD_SECTOR;
                end
            end
        endcase
        // Single-cycle commands ignore the address, except sector add, which keeps the sector bits.
        unique case (req.op)
            FCS_OP_RESET: begin
                cyc_addr = ADDR_ZERO;
                cyc_data = CMD_RESET;
            end
            FCS_OP_SUSPEND: begin
                cyc_addr = ADDR_ZERO;
                cyc_data = CMD_SUSPEND;
            end
            FCS_OP_RESUME: begin
                cyc_addr = ADDR_ZERO;
                cyc_data = CMD_RESUME;
            end
            FCS_OP_SECT_ADD: begin
                cyc_addr = {req.addr[ADDR_W-1:SECT_LSB], 16'h0000};
                cyc_data = CMD_SECTOR;
            end
            default: begin
            end
        endcase
    end

    // ******************************************************************
    // Bus cycle engine
    // ******************************************************************
    always_comb begin
        next_state = state;
        next_cyc = cyc;
        next_last_cyc = last_cyc;
        next_tmr = tmr;
        next_req = req;
        next_ctl = ctl;
        next_addr = addr;
        next_dq_out = dq_out;
        next_dq_oe = dq_oe;
        next_ready = ready;
        next_rd_valid = 1'b0;
        next_rd_data = rd_data;
        next_gap = (gap == SECT_GAP_CYC) ? gap : gap + 13'h0001;
        next_gap_exp = gap_exp | (gap == SECT_GAP_CYC);
        next_tfail = dq_s2[STATUS_TIMEOUT_BIT];
        next_ewin = dq_s2[STATUS_WINDOW_BIT];
        unique case (state)
            ST_IDLE: begin
                next_ctl = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
                next_dq_oe = 1'b0;
                if (i_req_valid && ready) begin
                    next_req = i_req;
                    next_ready = 1'b0;
                    next_cyc = 3'h0;
                    next_tmr = PHASE_CYC;
                    unique case (i_req.op)
                        FCS_OP_READ: begin
                            // Autoselect ids are plain reads too.
                            next_addr = i_req.addr;
                            next_ctl = '{ce_n: 1'b0, we_n: 1'b1,
                                oe_n: 1'b1};
                            next_state = ST_RD_GATE;
                        end
                        FCS_OP_RESET, FCS_OP_SUSPEND, FCS_OP_RESUME,
                        FCS_OP_SECT_ADD: begin
                            next_last_cyc = 3'h0;
                            next_state = ST_SETUP;
                        end
                        FCS_OP_AUTOSEL: begin
                            next_last_cyc = 3'h2;
                            next_state = ST_SETUP;
                        end
                        FCS_OP_PROGRAM: begin
                            next_last_cyc = 3'h3;
                            next_state = ST_SETUP;
                        end
                        default: begin
                            next_last_cyc = 3'h5;
                            next_state = ST_SETUP;
                        end
                    endcase
                end
            end
            ST_SETUP: begin
                // Address settles before select and strobe fall.
                next_addr = cyc_addr;
                next_dq_out = cyc_data;
                next_dq_oe = 1'b1;
                next_ctl = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
                // One extra count: the strobes only fall on the first
                // pulse edge, yet the low phase must last the full length.
                next_tmr = PHASE_CYC + 4'h1;
                next_state = ST_PULSE;
            end
            ST_PULSE: begin
                // Gate stays high so the low strobes form a write.
                next_ctl = '{ce_n: 1'b0, we_n: 1'b0, oe_n: 1'b1};
                next_tmr = tmr - 4'h1;
                if (tmr == 4'h1) begin
                    next_ctl = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
                    next_tmr = PHASE_CYC;
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Data and address held past the rising strobes.
                next_tmr = tmr - 4'h1;
                if (tmr == 4'h1) begin
                    if (cyc == last_cyc) begin
                        next_dq_oe = 1'b0;
                        next_ready = 1'b1;
                        next_state = ST_IDLE;
                        if (req.op == FCS_OP_SECT_ERASE ||
                            req.op == FCS_OP_SECT_ADD) begin
                            next_gap = 13'h0000;
                            next_gap_exp = 1'b0;
                        end
                    end else begin
                        next_cyc = cyc + 3'h1;
                        next_state = ST_SETUP;
                    end
                end
            end
            ST_RD_GATE: begin
                next_ctl = '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0};
                next_tmr = tmr - 4'h1;
                if (tmr == 4'h1) begin
                    // Taken from the second sync stage, which holds the
                    // pins as they stood once the gate had been low a cycle.
                    next_rd_data = dq_s2;
                    next_state = ST_RD_DONE;
                end
            end
            default: begin
                next_ctl = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
                next_rd_valid = 1'b1;
                next_ready = 1'b1;
                next_state = ST_IDLE;
            end
        endcase
        // Status flags only mean something on a read result.
        if (!(state == ST_RD_DONE)) begin
            next_tfail = tfail;
            next_ewin = ewin;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            cyc <= 3'h0;
            last_cyc <= 3'h0;
            tmr <= 4'h0;
            gap <= SECT_GAP_CYC;
            req <= '0;
            ctl <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
            addr <= '0;
            dq_out <= '0;
            dq_oe <= 1'b0;
            ready <= 1'b1;
            rd_valid <= 1'b0;
            rd_data <= '0;
            gap_exp <= 1'b1;
            tfail <= 1'b0;
            ewin <= 1'b0;
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            state <= next_state;
            cyc <= next_cyc;
            last_cyc <= next_last_cyc;
            tmr <= next_tmr;
            gap <= next_gap;
            req <= next_req;
            ctl <= next_ctl;
            addr <= next_addr;
            dq_out <= next_dq_out;
            dq_oe <= next_dq_oe;
            ready <= next_ready;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
            gap_exp <= next_gap_exp;
            tfail <= next_tfail;
            ewin <= next_ewin;
            dq_s1 <= i_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    assign o_req_ready = ready;
    assign o_rd_valid = rd_valid;
    assign o_rd_data = rd_data;
    assign o_gap_expired = gap_exp;
    assign o_timeout_fail = tfail;
    assign o_erase_window = ewin;
    assign o_ctl = ctl;
    assign o_addr = addr;
    assign o_dq_out = dq_out;
    assign o_dq_oe = dq_oe;
endmodule
`default_nettype wire

// >>> inc/fcs_pkg.sv
// Constants, command codes and carrier types for the flash command host.
// Assumes a byte-wide parallel flash with active-low select, write strobe
// and output gate, and a 100 MHz system clock on the host side.
//
// Overview of operation
// - Address on later fall, data on rise.
// - Autoselect held until host writes reset.
// - Host writes reset after timeout failure bit.
// - Program: two unlocks, A0, address and byte.
// - Chip erase: six writes ending in 10.
// - Sector erase: six writes, sector address, 30.
// - Keep gaps under 50us during sector adds.
// - Unlock AA@555, 55@2AA; codes 90 A0 80 10 30 F0.
// - Write only with select, strobe low, gate high.
package fcs_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 19'h00555;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 19'h002AA;
    localparam logic [DATA_W-1:0] DATA_UNLOCK1 = 8'hAA;
    localparam logic [DATA_W-1:0] DATA_UNLOCK2 = 8'h55;
    localparam logic [DATA_W-1:0] CMD_AUTOSEL = 8'h90;
    localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'hA0;
    localparam logic [DATA_W-1:0] CMD_ERASE = 8'h80;
    localparam logic [DATA_W-1:0] CMD_CHIP = 8'h10;
    localparam logic [DATA_W-1:0] CMD_SECTOR = 8'h30;
    localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;
    localparam logic [DATA_W-1:0] CMD_SUSPEND = 8'hB0;
    localparam logic [DATA_W-1:0] CMD_RESUME = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 19'h00000;
    localparam int SECT_LSB = 16;
    localparam int SECT_W = 3;
    localparam logic [ADDR_W-1:0] ID_LOW_MAKER = 19'h00000;
    localparam logic [ADDR_W-1:0] ID_LOW_DEVICE = 19'h00001;
    localparam logic [ADDR_W-1:0] ID_LOW_PROTECT = 19'h00002;
    localparam logic [ADDR_W-1:0] ID_LOW_CONT = 19'h00003;
    localparam int STATUS_TIMEOUT_BIT = 5;
    localparam int STATUS_WINDOW_BIT = 3;
    localparam int CLK_PERIOD_NS = 10;
    // Each strobe phase lasts this long; covers write pulse, hold and read gate.
    localparam int PHASE_NS = 40;
    localparam logic [3:0] PHASE_CYC =
        4'((PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Gap between sector adds must stay under this time.
    localparam int SECT_GAP_US = 50;
    localparam logic [12:0] SECT_GAP_CYC =
        13'((SECT_GAP_US * 1000) / CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        FCS_OP_READ,
        FCS_OP_RESET,
        FCS_OP_AUTOSEL,
        FCS_OP_PROGRAM,
        FCS_OP_CHIP_ERASE,
        FCS_OP_SECT_ERASE,
        FCS_OP_SECT_ADD,
        FCS_OP_SUSPEND,
        FCS_OP_RESUME
    } fcs_op_t;

    typedef struct packed {
        fcs_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fcs_req_t;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
    } fcs_ctl_t;
endpackage

// >>> bench/fcs_host_props.sv
// Checker for the flash pins of the command host.
// Assumes it is bound into fcs_host and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fcs_host_props
    import fcs_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic o_req_ready,
    input wire logic o_rd_valid,
    input wire fcs_ctl_t o_ctl,
    input wire logic [ADDR_W-1:0] o_addr,
    input wire logic [DATA_W-1:0] o_dq_out,
    input wire logic o_dq_oe
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    write_gate_a: assert property (
        !o_ctl.we_n |-> o_ctl.oe_n && !o_ctl.ce_n)
        else $error("write strobe without select or with gate open");
    drive_gate_a: assert property (o_dq_oe |-> o_ctl.oe_n)
        else $error("data driven while gate open");
    addr_hold_a: assert property (
        !o_ctl.ce_n && $past(!o_ctl.ce_n) |-> $stable(o_addr))
        else $error("address moved while selected");
    data_hold_a: assert property (
        !o_ctl.we_n |-> o_dq_oe && $stable(o_dq_out))
        else $error("data moved during write strobe");
    data_after_a: assert property (
        $rose(o_ctl.we_n) |-> o_dq_oe && $stable(o_dq_out))
        else $error("data dropped at strobe rise");
    strobe_low_a: assert property (
        $fell(o_ctl.we_n) |-> !o_ctl.we_n [*4])
        else $error("write strobe too short");
    strobe_high_a: assert property (
        $rose(o_ctl.we_n) |-> o_ctl.we_n [*4])
        else $error("write strobe high phase too short");
    busy_ready_a: assert property (!o_ctl.ce_n |-> !o_req_ready)
        else $error("ready while a bus cycle runs");
    read_end_a: assert property (
        $fell(o_ctl.oe_n) |-> ##[3:6] o_rd_valid)
        else $error("read did not complete");
    done_idle_a: assert property (
        o_rd_valid |-> o_req_ready && o_ctl == 3'b111)
        else $error("bus not idle after read");
endmodule
`default_nettype wire

// >>> bench/fcs_flash_model.sv
// Behavioural byte-wide flash answering the command host.
// Assumes the data bus level is resolved outside and fed to i_dq.
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_model
    import fcs_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'hC3, // Arbitrary value.
    parameter logic [7:0] DEVICE_ID = 8'h5C, // Arbitrary value.
    parameter logic [7:0] CONT_ID = 8'hE1, // Arbitrary value.
    parameter logic [7:0] PROT_MASK = 8'h20,
    parameter realtime PROG_NS = 1000.0,
    parameter realtime ERASE_NS = 3000.0
)
(
    input wire fcs_ctl_t i_ctl,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0] o_dq
);
    logic [7:0] mem [0:524287];
    logic [ADDR_W-1:0] lat_a;
    logic [7:0] last = 8'h00;
    logic [7:0] rd_val;
    logic [7:0] secs;
    int step = 0;
    bit auto = 0;
    bit win = 0;
    bit susp = 0;
    bit fail = 0;
    realtime busy_until = 0;
    realtime win_until = 0;
    wire wr = !i_ctl.ce_n && !i_ctl.we_n && i_ctl.oe_n;
    wire rd = !i_ctl.ce_n && !i_ctl.oe_n;
    task automatic erase(input logic [7:0] m);
        for (int i = 0; i < 524288; i++) if (m[i >> 16]) mem[i] = 8'hFF;
    endtask
    initial erase(8'hFF);
    always @(posedge wr) lat_a = i_addr;
    always @(negedge wr) begin : take
        logic [7:0] d;
        logic at5;
        logic u1;
        logic u2;
        d = i_dq;
        at5 = lat_a[10:0] == ADDR_UNLOCK1[10:0];
        u1 = at5 && d == DATA_UNLOCK1;
        u2 = lat_a[10:0] == ADDR_UNLOCK2[10:0] && d == DATA_UNLOCK2;
        if ($realtime < busy_until) begin
        end else if (win) begin
            if (d == CMD_SECTOR) begin
                secs[lat_a[18:16]] = 1'b1;
                win_until = $realtime + 50us;
            end else begin
                // Suspend stops the timer but keeps the sector list.
                susp = d == CMD_SUSPEND;
                win = 0;
            end
        end else if (d == CMD_RESET) begin
            step = 0;
            auto = 0;
            fail = 0;
        end else if (susp && step == 0 && d == CMD_RESUME) begin
            susp = 0;
            erase(secs);
            busy_until = $realtime + ERASE_NS;
        end else case (step)
            0: step = u1 ? 1 : 0;
            1: step = u2 ? 2 : 0;
            2: begin
                auto = auto || (at5 && d == CMD_AUTOSEL);
                step = !at5 ? 0 : d == CMD_PROGRAM ? 3 :
                    d == CMD_ERASE ? 4 : 0;
            end
            3: begin
                fail = fail || ((d & ~mem[lat_a]) != 8'h00);
                mem[lat_a] = mem[lat_a] & d;
                busy_until = $realtime + PROG_NS;
                step = 0;
            end
            4: step = u1 ? 5 : 0;
            5: step = u2 ? 6 : 0;
            6: begin
                if (at5 && d == CMD_CHIP) begin
                    erase(8'hFF);
                    busy_until = $realtime + ERASE_NS;
                end else if (d == CMD_SECTOR) begin
                    secs = 8'h01 << lat_a[18:16];
                    win = 1;
                    win_until = $realtime + 50us;
                end
                step = 0;
            end
            default: step = 0;
        endcase
    end
    always begin
        wait (win);
        #(win_until - $realtime);
        if (win && $realtime >= win_until) begin
            erase(secs);
            win = 0;
            busy_until = $realtime + ERASE_NS;
        end
    end
    always @(rd, i_addr) if (rd) begin
        if ($realtime < busy_until) rd_val = 8'h08;
        else if (win) rd_val = 8'h00;
        else if (fail) rd_val = 8'h20;
        else if (auto) case (i_addr[7:0])
            8'h00: rd_val = MAKER_ID;
            8'h01: rd_val = DEVICE_ID;
            8'h02: rd_val = {7'h00, PROT_MASK[i_addr[18:16]]};
            8'h03: rd_val = CONT_ID;
            default: rd_val = 8'h00;
        endcase
        else if (susp && secs[i_addr[18:16]]) rd_val = 8'h80;
        else rd_val = mem[i_addr];
    end
    // A released bus shows the inverse of the last byte, so no stale match.
    always @(negedge rd) last = rd_val;
    assign o_dq = rd ? rd_val : ~last;
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the flash command host.
// Assumes the flash model sits on the far side of the pins.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import fcs_pkg::*;
;
    localparam logic [7:0] MAKER = 8'hC3; // Arbitrary value.
    localparam logic [7:0] DEVICE = 8'h5C; // Arbitrary value.
    localparam logic [7:0] CONT = 8'hE1; // Arbitrary value.
    logic i_clock;
    logic i_sys_rst = 1'b1;
    logic valid = 1'b0;
    fcs_req_t req = '0;
    logic rdy, rd_valid, gap, tfail, ewin, dq_oe;
    logic [7:0] rd_data, dq_out, flash_dq, got;
    logic [18:0] addr;
    fcs_ctl_t ctl;
    wire logic [7:0] dq_bus = dq_oe ? dq_out : flash_dq;
    int err_total = 0;
    int tests_run = 0;
    fcs_host dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_req_valid(valid), .i_req(req), .o_req_ready(rdy),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_gap_expired(gap),
        .o_timeout_fail(tfail), .o_erase_window(ewin), .o_ctl(ctl),
        .o_addr(addr), .o_dq_out(dq_out), .o_dq_oe(dq_oe),
        .i_dq_in(dq_bus));
    fcs_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE),
        .CONT_ID(CONT)) flash (.i_ctl(ctl), .i_addr(addr), .i_dq(dq_bus),
        .o_dq(flash_dq));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task send(input fcs_op_t op, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req <= '{op, a, d};
        valid <= 1'b1;
        @(posedge i_clock);
        while (!rdy) @(posedge i_clock);
        valid <= 1'b0;
        do begin
            @(posedge i_clock);
            n++;
        end while (rdy !== 1'b1 && n < 200);
        if (rd_valid) got = rd_data;
        if (n >= 200) begin
            err_total++;
            $display("ERROR %0t: request never finished", $time);
        end
    endtask
    task rdc(input logic [18:0] a, input logic [7:0] e);
        send(FCS_OP_READ, a, 8'h00);
        check(got, e);
    endtask
    task poll(input logic [18:0] a, input logic [7:0] e);
        int k;
        k = 0;
        do begin
            send(FCS_OP_READ, a, 8'h00);
            k++;
        end while (got !== e && k < 1500);
        check(got, e);
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        rdc(19'h12345, 8'hFF);
        send(FCS_OP_PROGRAM, 19'h12345, 8'h5A);
        poll(19'h12345, 8'h5A);
        send(FCS_OP_PROGRAM, 19'h12345, 8'h0F);
        poll(19'h12345, 8'h20);
        check({7'h00, tfail}, 8'h01);
        send(FCS_OP_RESET, 19'h00000, 8'h00);
        rdc(19'h12345, 8'h0A);
        check({7'h00, tfail}, 8'h00);
        send(FCS_OP_PROGRAM, 19'h00200, 8'h33);
        send(FCS_OP_PROGRAM, 19'h00201, 8'h21);
        poll(19'h00200, 8'h33);
        rdc(19'h00201, 8'hFF);
        send(FCS_OP_AUTOSEL, 19'h00000, 8'h00);
        rdc(19'h7FF00, MAKER);
        rdc(19'h00001, DEVICE);
        rdc(19'h00003, CONT);
        rdc(19'h50002, 8'h01);
        rdc(19'h30002, 8'h00);
        rdc(19'h00000, MAKER);
        send(FCS_OP_RESET, 19'h00000, 8'h00);
        rdc(19'h12345, 8'h0A);
        send(FCS_OP_PROGRAM, 19'h20005, 8'h44);
        poll(19'h20005, 8'h44);
        send(FCS_OP_SECT_ERASE, 19'h20000, 8'h00);
        send(FCS_OP_RESET, 19'h00000, 8'h00);
        rdc(19'h20005, 8'h44);
        send(FCS_OP_SECT_ERASE, 19'h10000, 8'h00);
        send(FCS_OP_SECT_ADD, 19'h20000, 8'h00);
        check({7'h00, gap}, 8'h00);
        rdc(19'h20005, 8'h00);
        @(posedge i_clock);
        check({7'h00, ewin}, 8'h00);
        poll(19'h12345, 8'hFF);
        check({7'h00, gap}, 8'h01);
        rdc(19'h20005, 8'hFF);
        rdc(19'h00200, 8'h33);
        send(FCS_OP_PROGRAM, 19'h40010, 8'h55);
        poll(19'h40010, 8'h55);
        send(FCS_OP_SECT_ERASE, 19'h40000, 8'h00);
        send(FCS_OP_SUSPEND, 19'h00000, 8'h00);
        rdc(19'h40010, 8'h80);
        send(FCS_OP_PROGRAM, 19'h00210, 8'h12);
        poll(19'h00210, 8'h12);
        rdc(19'h40010, 8'h80);
        send(FCS_OP_RESUME, 19'h00000, 8'h00);
        poll(19'h40010, 8'hFF);
        send(FCS_OP_CHIP_ERASE, 19'h00000, 8'h00);
        rdc(19'h00200, 8'h08);
        check({7'h00, ewin}, 8'h01);
        poll(19'h00200, 8'hFF);
        results();
    end
    initial begin
        repeat (60000) @(posedge i_clock);
        err_total++;
        $display("ERROR %0t: watchdog expired", $time);
        results();
    end
endmodule
bind fcs_host fcs_host_props chk (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .o_req_ready(o_req_ready),
    .o_rd_valid(o_rd_valid), .o_ctl(o_ctl), .o_addr(o_addr),
    .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));
`default_nettype wire
